//--- rtl/pcs_pkg.sv
package pcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_MHZ           = 125;
  localparam int HOLD_TIME_US      = 722;
  localparam int HOLD_CYC          = HOLD_TIME_US * CLK_MHZ;
  // energy must persist this long; link pulses last about 100 ns
  localparam int SD_QUAL_NS        = 2000;
  localparam int SD_QUAL_CYC       = (SD_QUAL_NS * CLK_MHZ + 999) / 1000;
  localparam int GROUP_BITS        = 5;
  localparam int IDLE_SYNC_GROUPS  = 12;
  localparam int IDLE_SYNC_BITS    = IDLE_SYNC_GROUPS * GROUP_BITS;
  localparam int IDLE_RESTART_BITS = 58;
  localparam int STRAP_SETTLE      = 3;

  ////////////////////////////////////////////////////////////////////////////
  // scrambler generator x^11 + x^9 + 1
  localparam int         LFSR_W      = 11;
  localparam int         LFSR_TAP_HI = 10;
  localparam int         LFSR_TAP_LO = 8;
  localparam logic [10:0] LFSR_RESET = 11'h7ff;
  // upper seed bits, keep nonzero so the register can never lock at zero
  localparam logic [6:0] SEED_FILL   = 7'h5b;

  ////////////////////////////////////////////////////////////////////////////
  // code-groups, leftmost written bit goes on the line first
  localparam logic [4:0] CG_IDLE      = 5'h1f;
  localparam logic [4:0] CG_J         = 5'h18;
  localparam logic [4:0] CG_K         = 5'h11;
  localparam logic [4:0] CG_T         = 5'h0d;
  localparam logic [4:0] CG_R         = 5'h07;
  localparam logic [4:0] CG_HALT      = 5'h04;
  localparam logic [3:0] PREAMBLE_NIB = 4'h5;

  typedef enum logic [5:0] {
    TX_IDLE = 6'h01,
    TX_J    = 6'h02,
    TX_K    = 6'h04,
    TX_DATA = 6'h08,
    TX_T    = 6'h10,
    TX_R    = 6'h20
  } tx_state_t;

  typedef enum logic [2:0] {
    KIND_DATA = 3'h0,
    KIND_IDLE = 3'h1,
    KIND_CTRL = 3'h2,
    KIND_END  = 3'h3,
    KIND_BAD  = 3'h4
  } cg_kind_t;

  // data nibble to code-group
  function automatic logic [4:0] cg_encode(input logic [3:0] nib);
    logic [4:0] cg;
    cg = 5'h1e;
    case (nib)
      4'h0: cg = 5'h1e;
      4'h1: cg = 5'h09;
      4'h2: cg = 5'h14;
      4'h3: cg = 5'h15;
      4'h4: cg = 5'h0a;
      4'h5: cg = 5'h0b;
      4'h6: cg = 5'h0e;
      4'h7: cg = 5'h0f;
      4'h8: cg = 5'h12;
      4'h9: cg = 5'h13;
      4'ha: cg = 5'h16;
      4'hb: cg = 5'h17;
      4'hc: cg = 5'h1a;
      4'hd: cg = 5'h1b;
      4'he: cg = 5'h1c;
      default: cg = 5'h1d;
    endcase
    return cg;
  endfunction

  // code-group back to nibble, zero when not a data group
  function automatic logic [3:0] cg_nibble(input logic [4:0] cg);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (cg_encode(4'(i)) == cg) begin
        n = 4'(i);
      end
    end
    return n;
  endfunction

  function automatic cg_kind_t cg_kind(input logic [4:0] cg);
    cg_kind_t k;
    k = KIND_BAD;
    for (int i = 0; i < 16; i++) begin
      if (cg_encode(4'(i)) == cg) begin
        k = KIND_DATA;
      end
    end
    if (cg == CG_IDLE) begin
      k = KIND_IDLE;
    end else if (cg == CG_J || cg == CG_K || cg == CG_R) begin
      k = KIND_CTRL;
    end else if (cg == CG_T) begin
      k = KIND_END;
    end
    return k;
  endfunction

endpackage

//--- rtl/sync_two_ff.sv
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of asynchronous levels
module sync_two_ff #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

//--- rtl/lfsr_scrambler.sv
`timescale 1ns/1ps
// shift register generator shared by scrambler and descrambler
module lfsr_scrambler #(
  parameter int W = pcs_pkg::LFSR_W
) (
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         seed_load_i,
  input  wire logic [W-1:0] seed_i,
  input  wire logic         step_i,
  input  wire logic         force_i,
  input  wire logic         force_bit_i,
  output logic              key_o
);

  logic [W-1:0] state_q;

  assign key_o = state_q[pcs_pkg::LFSR_TAP_HI] ^ state_q[pcs_pkg::LFSR_TAP_LO];

  // seed wins over stepping; force lets the receiver steer the state
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= W'(pcs_pkg::LFSR_RESET);
    end else if (seed_load_i) begin
      state_q <= seed_i;
    end else if (step_i) begin
      state_q <= {state_q[W-2:0], force_i ? force_bit_i : key_o};
    end
  end

endmodule

//--- rtl/pcs_coding_path.sv
`timescale 1ns/1ps
// Behaviour
// - control groups inside data flag receive error
// - nibbles become 5-bit code-groups
// - first two preamble nibbles become J then K
// - frame end emits T then R
// - idles follow until transmit enable returns
// - serial bits XOR 11-bit register stepped only on valid bits
// - seed taken from strapped address bits 4..1
// - scrambled stream is NRZI encoded
// - ones alternate between two drive streams
// - output path carries MLT-3 only
// - serial receive stream delivered as nibbles
// - link pulses never raise signal detect
// - serial-to-parallel yields 5-bit symbols
// - descrambler XORs matching sequence with input
// - lock after twelve idle groups
// - hold timer restarts on 58 idle bits
// - hold expiry drops lock and reacquires
// - align on J K, then fixed boundary
// - bypass feeds aligner from NRZ decoder
// - standard code-group table with invalid codes
// - J K replaced by two preamble nibbles
module pcs_coding_path #(
  parameter int HOLD_CYC_P    = pcs_pkg::HOLD_CYC,
  parameter int SD_QUAL_CYC_P = pcs_pkg::SD_QUAL_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [4:0] strapped_port_address_pins_i,
  input  wire logic       mii_clk_i,
  input  wire logic       mii_tx_en_i,
  input  wire logic [3:0] mii_txd_i,
  output logic            tx_drv_p_o,
  output logic            tx_drv_n_o,
  input  wire logic       rx_mlt_p_i,
  input  wire logic       rx_mlt_n_i,
  input  wire logic       rx_energy_i,
  input  wire logic       descr_bypass_i,
  output logic [3:0]      rx_data_o,
  output logic            rx_dv_o,
  output logic            rx_er_o,
  output logic            rx_stb_o,
  output logic            signal_detect_o,
  output logic            descr_locked_o,
  output logic            rx_aligned_o
);

  localparam int HW = $clog2(HOLD_CYC_P + 1);
  localparam int SW = $clog2(SD_QUAL_CYC_P + 1);
  localparam int RW = 7;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  logic [14:0] pins_s;
  logic [4:0]  strap_s;
  logic        mii_clk_s;
  logic        tx_en_s;
  logic [3:0]  txd_s;
  logic        rx_p_s;
  logic        rx_n_s;
  logic        energy_s;
  logic        bypass_s;

  sync_two_ff #(
    .W (15)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({strapped_port_address_pins_i, mii_clk_i, mii_tx_en_i, mii_txd_i,
                 rx_mlt_p_i, rx_mlt_n_i, rx_energy_i, descr_bypass_i}),
    .q_o       (pins_s)
  );

  assign {strap_s, mii_clk_s, tx_en_s, txd_s, rx_p_s, rx_n_s, energy_s, bypass_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // seed capture after reset release
  logic [1:0]  strap_wait_q;
  logic        seed_taken_q;
  logic        tx_seed_load;
  logic [10:0] tx_seed;

  assign tx_seed_load = !seed_taken_q && (strap_wait_q == 2'(pcs_pkg::STRAP_SETTLE));
  assign tx_seed = {pcs_pkg::SEED_FILL, strap_s[4:1]};

  // wait out the synchroniser so the straps are real before latching
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_wait_q <= 2'h0;
      seed_taken_q <= 1'b0;
    end else begin
      if (strap_wait_q != 2'(pcs_pkg::STRAP_SETTLE)) begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end
      if (tx_seed_load) begin
        seed_taken_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit: nibble tick and code-group selection
  logic                mii_clk_q;
  logic                nib_tick;
  pcs_pkg::tx_state_t  tx_state_q;
  pcs_pkg::tx_state_t  tx_state_d;
  logic [4:0]          tx_cg_d;

  // sample mid-period on the falling edge, away from the MAC's launch edge
  assign nib_tick = mii_clk_q && !mii_clk_s;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mii_clk_q <= 1'b0;
    end else begin
      mii_clk_q <= mii_clk_s;
    end
  end

  // next group from state and enable
  always_comb begin
    tx_state_d = tx_state_q;
    tx_cg_d    = pcs_pkg::CG_IDLE;
    case (tx_state_q)
      pcs_pkg::TX_IDLE, pcs_pkg::TX_R: begin
        if (tx_en_s) begin
          tx_state_d = pcs_pkg::TX_J;
          tx_cg_d    = pcs_pkg::CG_J;
        end else begin
          tx_state_d = pcs_pkg::TX_IDLE;
          tx_cg_d    = pcs_pkg::CG_IDLE;
        end
      end
      pcs_pkg::TX_J: begin
        tx_state_d = pcs_pkg::TX_K;
        tx_cg_d    = pcs_pkg::CG_K;
      end
      pcs_pkg::TX_K, pcs_pkg::TX_DATA: begin
        if (tx_en_s) begin
          tx_state_d = pcs_pkg::TX_DATA;
          tx_cg_d    = pcs_pkg::cg_encode(txd_s);
        end else begin
          tx_state_d = pcs_pkg::TX_T;
          tx_cg_d    = pcs_pkg::CG_T;
        end
      end
      pcs_pkg::TX_T: begin
        tx_state_d = pcs_pkg::TX_R;
        tx_cg_d    = pcs_pkg::CG_R;
      end
      default: begin
        tx_state_d = pcs_pkg::TX_IDLE;
        tx_cg_d    = pcs_pkg::CG_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_state_q <= pcs_pkg::TX_IDLE;
    end else if (nib_tick) begin
      tx_state_q <= tx_state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit: serialiser, scrambler, NRZI, MLT-3
  logic [4:0] tx_sr_q;
  logic [2:0] tx_cnt_q;
  logic       tx_bit_vld;
  logic       tx_key;
  logic       tx_scr;
  logic       tx_nrzi_q;
  logic       tx_nrzi_prev_q;
  logic [1:0] mlt_phase_q;

  assign tx_bit_vld = (tx_cnt_q != 3'h0);

  // one group per tick, five bits on consecutive cycles
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_sr_q  <= pcs_pkg::CG_IDLE;
      tx_cnt_q <= 3'h0;
    end else if (nib_tick) begin
      tx_sr_q  <= tx_cg_d;
      tx_cnt_q <= 3'(pcs_pkg::GROUP_BITS);
    end else if (tx_bit_vld) begin
      tx_sr_q  <= {tx_sr_q[3:0], 1'b0};
      tx_cnt_q <= tx_cnt_q - 3'h1;
    end
  end

  lfsr_scrambler #(
    .W (pcs_pkg::LFSR_W)
  ) u_tx_lfsr (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .seed_load_i (tx_seed_load),
    .seed_i      (tx_seed),
    .step_i      (tx_bit_vld),
    .force_i     (1'b0),
    .force_bit_i (1'b0),
    .key_o       (tx_key)
  );

  assign tx_scr = tx_sr_q[4] ^ tx_key;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_nrzi_q      <= 1'b0;
      tx_nrzi_prev_q <= 1'b0;
    end else begin
      tx_nrzi_prev_q <= tx_nrzi_q;
      if (tx_bit_vld && tx_scr) begin
        tx_nrzi_q <= !tx_nrzi_q;
      end
    end
  end

  // each transition steps 0,+,0,- so ones alternate between streams
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mlt_phase_q <= 2'h0;
      tx_drv_p_o  <= 1'b0;
      tx_drv_n_o  <= 1'b0;
    end else begin
      if (tx_nrzi_q ^ tx_nrzi_prev_q) begin
        mlt_phase_q <= mlt_phase_q + 2'h1;
      end
      tx_drv_p_o <= (mlt_phase_q == 2'h1);
      tx_drv_n_o <= (mlt_phase_q == 2'h3);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive: signal detect and line decoding
  logic [SW-1:0] sd_cnt_q;
  logic [1:0]    rx_lvl_q;
  logic          rx_nrzi_q;
  logic          rx_nrzi_prev_q;
  logic          rx_nrz;

  // require sustained energy, short pulses never qualify
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sd_cnt_q        <= '0;
      signal_detect_o <= 1'b0;
    end else begin
      if (!energy_s) begin
        sd_cnt_q <= '0;
      end else if (sd_cnt_q != SW'(SD_QUAL_CYC_P)) begin
        sd_cnt_q <= sd_cnt_q + SW'(1);
      end
      signal_detect_o <= energy_s && (sd_cnt_q == SW'(SD_QUAL_CYC_P));
    end
  end

  // MLT-3 level change gives an NRZI transition
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_lvl_q       <= 2'h0;
      rx_nrzi_q      <= 1'b0;
      rx_nrzi_prev_q <= 1'b0;
    end else begin
      rx_lvl_q       <= {rx_p_s, rx_n_s};
      rx_nrzi_prev_q <= rx_nrzi_q;
      if ({rx_p_s, rx_n_s} != rx_lvl_q) begin
        rx_nrzi_q <= !rx_nrzi_q;
      end
    end
  end

  assign rx_nrz = rx_nrzi_q ^ rx_nrzi_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // receive: descrambler with idle lock and hold timer
  logic          rx_key;
  logic          rx_ud;
  logic          rx_drop;
  logic          rx_seed_load;
  logic          run_hit;
  logic [RW-1:0] idle_run_q;
  logic [HW-1:0] hold_q;

  assign rx_ud        = rx_nrz ^ rx_key;
  assign run_hit      = rx_ud && (idle_run_q >= RW'(pcs_pkg::IDLE_RESTART_BITS - 1));
  assign rx_drop      = descr_locked_o && (hold_q == '0) && !run_hit;
  assign rx_seed_load = !signal_detect_o || rx_drop;

  // unlocked, the register is loaded with the inverted line, since idle is all ones
  lfsr_scrambler #(
    .W (pcs_pkg::LFSR_W)
  ) u_rx_lfsr (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .seed_load_i (rx_seed_load),
    .seed_i      (pcs_pkg::LFSR_RESET),
    .step_i      (1'b1),
    .force_i     (!descr_locked_o),
    .force_bit_i (!rx_nrz),
    .key_o       (rx_key)
  );

  // run of unscrambled ones, saturating
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idle_run_q <= '0;
    end else if (rx_seed_load || !rx_ud) begin
      idle_run_q <= '0;
    end else if (idle_run_q != {RW{1'b1}}) begin
      idle_run_q <= idle_run_q + RW'(1);
    end
  end

  // lock state and hold countdown
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      descr_locked_o <= 1'b0;
      hold_q         <= '0;
    end else if (rx_seed_load) begin
      descr_locked_o <= 1'b0;
      hold_q         <= '0;
    end else if (!descr_locked_o) begin
      if (rx_ud && idle_run_q == RW'(pcs_pkg::IDLE_SYNC_BITS - 1)) begin
        descr_locked_o <= 1'b1;
        hold_q         <= HW'(HOLD_CYC_P);
      end
    end else if (run_hit) begin
      hold_q <= HW'(HOLD_CYC_P);
    end else begin
      hold_q <= hold_q - HW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive: alignment and decoding
  logic              al_bit;
  logic              al_vld;
  logic [9:0]        al_sr_q;
  logic [9:0]        al_sr_d;
  logic [2:0]        grp_cnt_q;
  logic              pre_pend_q;
  logic              idle_seen_q;
  logic [4:0]        grp;
  pcs_pkg::cg_kind_t grp_kind;

  assign al_bit   = bypass_s ? rx_nrz : rx_ud;
  assign al_vld   = bypass_s ? signal_detect_o : descr_locked_o;
  assign al_sr_d  = {al_sr_q[8:0], al_bit};
  assign grp      = al_sr_d[4:0];
  assign grp_kind = pcs_pkg::cg_kind(grp);

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      al_sr_q      <= 10'h3ff;
      grp_cnt_q    <= 3'h0;
      rx_aligned_o <= 1'b0;
      pre_pend_q   <= 1'b0;
      idle_seen_q  <= 1'b0;
      rx_data_o    <= 4'h0;
      rx_dv_o      <= 1'b0;
      rx_er_o      <= 1'b0;
      rx_stb_o     <= 1'b0;
    end else begin
      al_sr_q    <= al_sr_d;
      rx_stb_o   <= 1'b0;
      pre_pend_q <= 1'b0;
      if (!al_vld) begin
        rx_aligned_o <= 1'b0;
        rx_dv_o      <= 1'b0;
        rx_er_o      <= 1'b0;
      end else if (!rx_aligned_o) begin
        if (al_sr_d == {pcs_pkg::CG_J, pcs_pkg::CG_K}) begin
          rx_aligned_o <= 1'b1;
          grp_cnt_q    <= 3'h0;
          idle_seen_q  <= 1'b0;
          rx_data_o    <= pcs_pkg::PREAMBLE_NIB;
          rx_dv_o      <= 1'b1;
          rx_er_o      <= 1'b0;
          rx_stb_o     <= 1'b1;
          pre_pend_q   <= 1'b1;
        end
      end else if (pre_pend_q) begin
        rx_data_o <= pcs_pkg::PREAMBLE_NIB;
        rx_stb_o  <= 1'b1;
        grp_cnt_q <= grp_cnt_q + 3'h1;
      end else if (grp_cnt_q != 3'(pcs_pkg::GROUP_BITS - 1)) begin
        grp_cnt_q <= grp_cnt_q + 3'h1;
      end else begin
        grp_cnt_q <= 3'h0;
        rx_stb_o  <= 1'b1;
        rx_data_o <= pcs_pkg::cg_nibble(grp);
        case (grp_kind)
          pcs_pkg::KIND_DATA: begin
            rx_er_o     <= 1'b0;
            idle_seen_q <= 1'b0;
          end
          pcs_pkg::KIND_END: begin
            rx_aligned_o <= 1'b0;
            rx_dv_o      <= 1'b0;
            rx_er_o      <= 1'b0;
          end
          pcs_pkg::KIND_IDLE: begin
            // idle in data, second one ends the frame
            idle_seen_q <= 1'b1;
            if (idle_seen_q) begin
              rx_aligned_o <= 1'b0;
              rx_dv_o      <= 1'b0;
              rx_er_o      <= 1'b0;
            end else begin
              rx_er_o <= 1'b1;
            end
          end
          default: begin
            rx_er_o     <= 1'b1;
            idle_seen_q <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

//--- test/pcs_checker.sv
`timescale 1ns/1ps
// watches line drive and receive framing at the top ports
module pcs_checker #(
  parameter int HOLD_CYC_P    = 500,
  parameter int SD_QUAL_CYC_P = 20
) (
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       tx_drv_p_o,
  input wire logic       tx_drv_n_o,
  input wire logic       rx_energy_i,
  input wire logic       descr_bypass_i,
  input wire logic [3:0] rx_data_o,
  input wire logic       rx_dv_o,
  input wire logic       rx_stb_o,
  input wire logic       signal_detect_o,
  input wire logic       descr_locked_o,
  input wire logic       rx_aligned_o
);
  int   en_run_q;
  int   sd_run_q;
  int   lk_run_q;
  logic neg_last_q;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // run lengths; raw energy is counted so the sync delay only adds margin
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_run_q <= 0;
      sd_run_q <= 0;
      lk_run_q <= 0;
    end else begin
      en_run_q <= rx_energy_i ? en_run_q + 1 : 0;
      sd_run_q <= signal_detect_o ? sd_run_q + 1 : 0;
      lk_run_q <= descr_locked_o ? lk_run_q + 1 : 0;
    end
  end

  // last nonzero line level, minus assumed before the first step
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      neg_last_q <= 1'b1;
    end else if (tx_drv_p_o) begin
      neg_last_q <= 1'b0;
    end else if (tx_drv_n_o) begin
      neg_last_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_drive_exclusive: assert property (!(tx_drv_p_o && tx_drv_n_o))
    else $error("both drive streams high");
  a_alt_pos: assert property ($rose(tx_drv_p_o) |-> neg_last_q)
    else $error("plus level repeated without minus");
  a_alt_neg: assert property ($rose(tx_drv_n_o) |-> !neg_last_q)
    else $error("minus level repeated without plus");
  a_sd_qualified: assert property ($rose(signal_detect_o) |-> en_run_q >= SD_QUAL_CYC_P)
    else $error("signal detect on short energy");
  a_lock_after_idle: assert property (
    $rose(descr_locked_o) && !descr_bypass_i |-> sd_run_q >= 59)
    else $error("lock before twelve idles");
  a_hold_expiry: assert property (
    $fell(descr_locked_o) && signal_detect_o && !descr_bypass_i |-> lk_run_q >= HOLD_CYC_P - 1)
    else $error("lock dropped before hold timeout");
  a_pre_nibble: assert property (
    $rose(rx_dv_o) |-> rx_stb_o && rx_aligned_o && rx_data_o == pcs_pkg::PREAMBLE_NIB)
    else $error("frame did not open with preamble");
  a_grp_spacing: assert property (
    rx_stb_o && rx_dv_o && $past(rx_stb_o) |-> ##1 (!rx_stb_o) [*3] ##1 rx_stb_o)
    else $error("first group not five bits after delimiter");
  a_dv_aligned: assert property (rx_stb_o && rx_dv_o |-> rx_aligned_o)
    else $error("frame data while unaligned");
endmodule

bind pcs_coding_path pcs_checker #(
  .HOLD_CYC_P   (HOLD_CYC_P),
  .SD_QUAL_CYC_P(SD_QUAL_CYC_P)
) u_chk (.*);

//--- test/mac_model.sv
`timescale 1ns/1ps
// behavioural MAC: free-running nibble clock, frames on request
module mac_model (
  output logic       mii_clk_o,
  output logic       mii_tx_en_o,
  output logic [3:0] mii_txd_o
);
  initial begin
    mii_clk_o   = 1'b0;
    mii_tx_en_o = 1'b0;
    mii_txd_o   = 4'h0;
  end

  // 80 ns nibble clock
  always #40 mii_clk_o = ~mii_clk_o;

  // two preamble nibbles then payload; change on rising, design takes falling
  task automatic send(input int n);
    for (int i = 0; i < n + 2; i++) begin
      @(posedge mii_clk_o);
      mii_tx_en_o <= 1'b1;
      mii_txd_o   <= (i < 2) ? 4'h5 : 4'(i) ^ 4'ha;
    end
    @(posedge mii_clk_o);
    mii_tx_en_o <= 1'b0;
  endtask
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  logic       sys_clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [4:0] strapped_port_address_pins_i;
  logic       mii_clk_i;
  logic       mii_tx_en_i;
  logic [3:0] mii_txd_i;
  logic       tx_drv_p_o;
  logic       tx_drv_n_o;
  logic       rx_mlt_p_i;
  logic       rx_mlt_n_i;
  logic       rx_energy_i = 1'b0;
  logic       descr_bypass_i = 1'b0;
  logic [3:0] rx_data_o;
  logic       rx_dv_o;
  logic       rx_er_o;
  logic       rx_stb_o;
  logic       signal_detect_o;
  logic       descr_locked_o;
  logic       rx_aligned_o;
  int         n_errors = 0;
  int         checks_done = 0;
  int         seed = 32'hb70d2421;
  int         np = 0;
  int         nn = 0;
  logic [10:0] s_q = 11'h7ff;
  logic [1:0] ph_q = 2'd0;
  logic       scr_q = 1'b1;
  logic [5:0] exp_q[$];
  logic [5:0] got_q[$];
  localparam logic [4:0] TBL [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
    5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  localparam logic [4:0] BAD [6] = '{5'h00, 5'h1f, 5'h18, 5'h11, 5'h07, 5'h04};

  always #4 sys_clk_i = ~sys_clk_i;

  pcs_coding_path #(.HOLD_CYC_P(500), .SD_QUAL_CYC_P(20)) u_dut (.*);
  mac_model u_mac (.mii_clk_o(mii_clk_i), .mii_tx_en_o(mii_tx_en_i), .mii_txd_o(mii_txd_i));

  // strobes collected as {dv, er, nibble}; drive levels counted
  always @(posedge sys_clk_i) begin
    if (rx_stb_o === 1'b1) got_q.push_back({rx_dv_o, rx_er_o, rx_data_o});
    if (tx_drv_p_o === 1'b1) np++;
    if (tx_drv_n_o === 1'b1) nn++;
  end

  // transmit monitor: a drive change is a line one; after several idle
  // nibbles the inverted line bits are the key, which must obey x^11+x^9+1
  int          en_lo = 0;
  int          ph = 0;
  logic [1:0]  lv_q = 2'h0;
  logic [10:0] k_q = 11'h0;
  logic        lb;

  always @(negedge mii_clk_i) begin
    en_lo = mii_tx_en_i ? 0 : en_lo + 1;
    ph = 0;
  end

  // five line bits trail each MAC falling edge by seven to eleven cycles
  always @(posedge sys_clk_i) begin
    ph++;
    lb = ({tx_drv_p_o, tx_drv_n_o} != lv_q);
    lv_q = {tx_drv_p_o, tx_drv_n_o};
    if (ph >= 7 || ph == 1) begin
      if (en_lo >= 6 && !sys_rst_i) begin
        chk({5'h0, !lb}, {5'h0, k_q[10] ^ k_q[8]});
      end
      k_q = {k_q[9:0], !lb};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // far transmitter: x^11+x^9+1 key, NRZI one steps the MLT-3 phase
  task automatic bitx(input logic b);
    logic k;
    k = scr_q & (s_q[10] ^ s_q[8]);
    s_q = {s_q[9:0], s_q[10] ^ s_q[8]};
    @(posedge sys_clk_i);
    if (b ^ k) ph_q = ph_q + 2'd1;
    rx_mlt_p_i <= (ph_q == 2'd1);
    rx_mlt_n_i <= (ph_q == 2'd3);
  endtask

  task automatic grp(input logic [4:0] cg);
    for (int i = 4; i >= 0; i--) bitx(cg[i]);
  endtask

  task automatic idles(input int n);
    repeat (n) grp(5'h1f);
  endtask

  // one frame, optional control group in the second data slot
  task automatic frame(input int n, input logic [4:0] bad, input logic use_bad);
    logic [3:0] d;
    got_q.delete();
    grp(5'h18);
    grp(5'h11);
    exp_q.push_back(6'h25);
    exp_q.push_back(6'h25);
    for (int i = 0; i < n; i++) begin
      d = (n > 100) ? 4'h0 : 4'($random(seed));
      if (use_bad && i == 1) begin
        grp(bad);
        exp_q.push_back(6'h30);
      end else begin
        grp(TBL[d]);
        exp_q.push_back({2'b10, d});
      end
    end
    grp(5'h0d);
    grp(5'h07);
    exp_q.push_back(6'h00);
    // enough idle to reload the hold timer, too little to relock after a drop
    idles(11);
  endtask

  // end markers compare dv and er only
  task automatic cmpq();
    logic [5:0] e;
    logic [5:0] g;
    chk({5'h0, got_q.size() >= exp_q.size()}, 6'h01);
    while (exp_q.size() > 0 && got_q.size() > 0) begin
      e = exp_q.pop_front();
      g = got_q.pop_front();
      chk(e[5] ? g : {g[5:4], 4'h0}, e);
    end
    exp_q.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rx_mlt_p_i <= 1'b0;
    rx_mlt_n_i <= 1'b0;
    // any strap value must still give a working seed
    strapped_port_address_pins_i <= 5'($random(seed));
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    // link-pulse sized bursts of energy
    repeat (6) begin
      @(posedge sys_clk_i);
      rx_energy_i <= 1'b1;
      repeat (13) @(posedge sys_clk_i);
      rx_energy_i <= 1'b0;
      repeat (30) @(posedge sys_clk_i);
    end
    chk({5'h0, signal_detect_o}, 6'h00);
    rx_energy_i <= 1'b1;
    fork
      u_mac.send(24);
      begin
        idles(10);
        chk({5'h0, descr_locked_o}, 6'h00);
        // a silent line could fake a delimiter, so idle past the MAC frame
        idles(50);
        chk({5'h0, descr_locked_o}, 6'h01);
      end
    join
    chk({4'h0, np > 0, nn > 0}, 6'h03);
    for (int k = 0; k < 7; k++) begin
      frame(4 + ($unsigned($random(seed)) % 8), BAD[k % 6], k < 6);
      cmpq();
    end
    idles(150);
    chk({5'h0, descr_locked_o}, 6'h01);
    frame(120, 5'h00, 1'b0);
    exp_q.delete();
    chk({5'h0, descr_locked_o}, 6'h00);
    idles(30);
    chk({5'h0, descr_locked_o}, 6'h01);
    descr_bypass_i <= 1'b1;
    scr_q = 1'b0;
    idles(20);
    frame(6, 5'h00, 1'b0);
    cmpq();
    end_of_test();
  end

  // cut a hang short well past the expected run time
  initial begin
    #200000;
    n_errors++;
    $display("ERROR %0t: timeout", $time);
    end_of_test();
  end
endmodule
